/* File: src/tsc_setup_regs.sv */
// setup register, limit registers, ambient register and event control
// assumes the serial engine gives one-cycle read and write strobes on a pointer
`timescale 1ns/100ps
`default_nettype none
// Contract
// - bits 10:9 pick release margin none, 1.5, 3.0 or 6.0 degrees
// - margin writes ignored while either lock is set
// - bit 8 halts conversions; ambient keeps last converted value
// - halted: conversion off, registers usable, event deasserted
// - halt cannot be set while locked, may be cleared while locked
// - bit 7 blocks critical limit writes, sticky until reset
// - bit 6 blocks high and low limit writes, sticky until reset
// - writing 1 to bit 5 clears interrupt; reads zero
// - clear written while halted is applied after halt ends
// - bit 4 reads event asserted, zero while halted
// - bit 3 enables the event output
// - enable, polarity and mode writes ignored while locked
// - bit 2 selects critical-only events; frozen while window locked
// - bit 1 gives active-high event when set, active-low when clear
// - bit 0 selects interrupt mode when set, comparator when clear
// - event settings writable while halted, output stays deasserted
// - capability alarm bit always reads one
// - bits 15:11 read zero; all fields zero after reset
// - flags: reading at or above critical, above high, below low
// - enabled event asserts when reading leaves the limits
module tsc_setup_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port from the serial engine
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // converter
  input wire logic [12:0] conv_data,
  input wire logic conv_valid,
  output logic conv_run,
  // event pin
  output logic evt_pin
);

  tsc_pkg::tsc_cfg_t cfg;
  tsc_pkg::tsc_flags_t raw;
  tsc_pkg::tsc_flags_t held;
  logic [10:0] high_lim;
  logic [10:0] low_lim;
  logic [10:0] crit_lim;
  logic [12:0] amb;
  logic locked;
  logic wr_setup;
  logic int_clr;
  logic cond;
  logic evt_stat;
  logic [15:0] next_rdata;
  logic next_hit;

  // lock state before this write decides what the write may touch
  assign locked = cfg.crit_lock | cfg.win_lock;
  assign wr_setup = reg_wr & (reg_addr == tsc_pkg::ADDR_SETUP);

  // margin selector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.hyst <= tsc_pkg::CFG_RESET.hyst;
    end else if (wr_setup && !locked) begin
      cfg.hyst <= reg_wdata[tsc_pkg::B_HYST_HI:tsc_pkg::B_HYST_LO];
    end
  end

  // halt: setting refused while locked, clearing always taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.halt <= tsc_pkg::CFG_RESET.halt;
    end else if (wr_setup) begin
      if (!reg_wdata[tsc_pkg::B_HALT]) begin
        cfg.halt <= 1'b0;
      end else if (!locked) begin
        cfg.halt <= 1'b1;
      end
    end
  end

  // locks only ever set by software; reset is the sole way out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.crit_lock <= tsc_pkg::CFG_RESET.crit_lock;
      cfg.win_lock <= tsc_pkg::CFG_RESET.win_lock;
    end else if (wr_setup) begin
      cfg.crit_lock <= cfg.crit_lock | reg_wdata[tsc_pkg::B_CRIT_LOCK];
      cfg.win_lock <= cfg.win_lock | reg_wdata[tsc_pkg::B_WIN_LOCK];
    end
  end

  // event enable, polarity and mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.evt_en <= tsc_pkg::CFG_RESET.evt_en;
      cfg.evt_pol <= tsc_pkg::CFG_RESET.evt_pol;
      cfg.evt_mode <= tsc_pkg::CFG_RESET.evt_mode;
    end else if (wr_setup && !locked) begin
      cfg.evt_en <= reg_wdata[tsc_pkg::B_EVT_EN];
      cfg.evt_pol <= reg_wdata[tsc_pkg::B_EVT_POL];
      cfg.evt_mode <= reg_wdata[tsc_pkg::B_EVT_MODE];
    end
  end

  // source select is frozen by the window lock alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.evt_sel <= tsc_pkg::CFG_RESET.evt_sel;
    end else if (wr_setup && !cfg.win_lock) begin
      cfg.evt_sel <= reg_wdata[tsc_pkg::B_EVT_SEL];
    end
  end

  // clear is a strobe, never stored as a field
  assign int_clr = wr_setup & reg_wdata[tsc_pkg::B_INT_CLR];

  // high and low limits behind the window lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_lim <= tsc_pkg::LIM_RESET;
      low_lim <= tsc_pkg::LIM_RESET;
    end else if (reg_wr && !cfg.win_lock) begin
      if (reg_addr == tsc_pkg::ADDR_HIGH) begin
        high_lim <= reg_wdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB];
      end
      if (reg_addr == tsc_pkg::ADDR_LOW) begin
        low_lim <= reg_wdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB];
      end
    end
  end

  // critical limit behind its own lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_lim <= tsc_pkg::LIM_RESET;
    end else if (reg_wr && !cfg.crit_lock && reg_addr == tsc_pkg::ADDR_CRIT) begin
      crit_lim <= reg_wdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB];
    end
  end

  // ambient reading: results arriving in halt are dropped, last value kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amb <= tsc_pkg::AMB_RESET;
    end else if (conv_valid && !cfg.halt) begin
      amb <= conv_data;
    end
  end

  // converter runs only outside halt
  assign conv_run = ~cfg.halt;

  // comparisons on quarter degrees; finer ambient bits are dropped
  tsc_limit_cmp u_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .amb_q(amb[12:2]),
    .high_q(high_lim),
    .low_q(low_lim),
    .crit_q(crit_lim),
    .hyst(cfg.hyst),
    .raw(raw),
    .held(held)
  );

  // source selection for the event
  assign cond = cfg.evt_sel ? held.crit : (held.crit | held.high | held.low);

  tsc_event_out u_evt (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .int_clr(int_clr),
    .cond(cond),
    .evt_pin(evt_pin),
    .evt_stat(evt_stat)
  );

  // read mux; unmapped pointers give zero and no hit
  always_comb begin
    next_rdata = 16'h0000;
    next_hit = 1'b1;
    unique case (reg_addr)
      tsc_pkg::ADDR_CAP: begin
        next_rdata = tsc_pkg::CAP_VALUE;
      end
      tsc_pkg::ADDR_SETUP: begin
        next_rdata[tsc_pkg::B_HYST_HI:tsc_pkg::B_HYST_LO] = cfg.hyst;
        next_rdata[tsc_pkg::B_HALT] = cfg.halt;
        next_rdata[tsc_pkg::B_CRIT_LOCK] = cfg.crit_lock;
        next_rdata[tsc_pkg::B_WIN_LOCK] = cfg.win_lock;
        next_rdata[tsc_pkg::B_EVT_STAT] = evt_stat;
        next_rdata[tsc_pkg::B_EVT_EN] = cfg.evt_en;
        next_rdata[tsc_pkg::B_EVT_SEL] = cfg.evt_sel;
        next_rdata[tsc_pkg::B_EVT_POL] = cfg.evt_pol;
        next_rdata[tsc_pkg::B_EVT_MODE] = cfg.evt_mode;
      end
      tsc_pkg::ADDR_HIGH: begin
        next_rdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB] = high_lim;
      end
      tsc_pkg::ADDR_LOW: begin
        next_rdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB] = low_lim;
      end
      tsc_pkg::ADDR_CRIT: begin
        next_rdata[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB] = crit_lim;
      end
      tsc_pkg::ADDR_AMB: begin
        next_rdata[12:0] = amb;
        next_rdata[tsc_pkg::AMB_CRIT_POS] = raw.crit;
        next_rdata[tsc_pkg::AMB_HIGH_POS] = raw.high;
        next_rdata[tsc_pkg::AMB_LOW_POS] = raw.low;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  // read data captured on the read strobe and held until the next one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

endmodule : tsc_setup_regs
`default_nettype wire

/* File: src/tsc_pkg.sv */
// constants and carrier types for the temperature monitor setup and event block
// assumes a 16-bit register port fed by the serial bus engine, pointer in 4 bits
package tsc_pkg;

  // register pointers
  localparam logic [3:0] ADDR_CAP = 4'h0;
  localparam logic [3:0] ADDR_SETUP = 4'h1;
  localparam logic [3:0] ADDR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_LOW = 4'h3;
  localparam logic [3:0] ADDR_CRIT = 4'h4;
  localparam logic [3:0] ADDR_AMB = 4'h5;

  // setup register field positions
  localparam int B_HYST_HI = 10;
  localparam int B_HYST_LO = 9;
  localparam int B_HALT = 8;
  localparam int B_CRIT_LOCK = 7;
  localparam int B_WIN_LOCK = 6;
  localparam int B_INT_CLR = 5;
  localparam int B_EVT_STAT = 4;
  localparam int B_EVT_EN = 3;
  localparam int B_EVT_SEL = 2;
  localparam int B_EVT_POL = 1;
  localparam int B_EVT_MODE = 0;

  // capability register: only the alarm bit is kept here
  localparam logic [15:0] CAP_VALUE = 16'h0001;

  // limit registers keep bits 12..2, quarter degree steps
  localparam int LIM_MSB = 12;
  localparam int LIM_LSB = 2;
  localparam logic [10:0] LIM_RESET = 11'h000;

  // ambient register: flags on top, 13 bits of sixteenth degree data
  localparam int AMB_CRIT_POS = 15;
  localparam int AMB_HIGH_POS = 14;
  localparam int AMB_LOW_POS = 13;
  localparam logic [12:0] AMB_RESET = 13'h0000;

  // release margins in quarter degrees
  localparam logic [1:0] HYST_NONE = 2'h0;
  localparam logic [1:0] HYST_1P5 = 2'h1;
  localparam logic [1:0] HYST_3P0 = 2'h2;
  localparam logic [1:0] HYST_6P0 = 2'h3;
  localparam logic signed [11:0] MARGIN_NONE = 12'sh000;
  localparam logic signed [11:0] MARGIN_1P5 = 12'sh006;
  localparam logic signed [11:0] MARGIN_3P0 = 12'sh00c;
  localparam logic signed [11:0] MARGIN_6P0 = 12'sh018;

  typedef struct packed {
    logic [1:0] hyst;
    logic halt;
    logic crit_lock;
    logic win_lock;
    logic evt_en;
    logic evt_sel;
    logic evt_pol;
    logic evt_mode;
  } tsc_cfg_t;

  localparam tsc_cfg_t CFG_RESET = '{hyst: 2'h0, halt: 1'b0, crit_lock: 1'b0, win_lock: 1'b0,
                                     evt_en: 1'b0, evt_sel: 1'b0, evt_pol: 1'b0, evt_mode: 1'b0};

  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } tsc_flags_t;

  localparam tsc_flags_t FLAGS_RESET = 3'h0;

endpackage : tsc_pkg

/* File: src/tsc_limit_cmp.sv */
// limit comparisons of the ambient reading, raw and with release margin
// assumes limits and reading are stable two's complement quarter degree values
`timescale 1ns/100ps
`default_nettype none
module tsc_limit_cmp (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // values
  input wire logic signed [10:0] amb_q,
  input wire logic signed [10:0] high_q,
  input wire logic signed [10:0] low_q,
  input wire logic signed [10:0] crit_q,
  input wire logic [1:0] hyst,
  // results
  output tsc_pkg::tsc_flags_t raw,
  output tsc_pkg::tsc_flags_t held
);

  logic signed [11:0] margin;
  logic signed [11:0] amb_x;
  logic signed [11:0] high_x;
  logic signed [11:0] low_x;
  logic signed [11:0] crit_x;

  // widen by one bit so the margin can never wrap a limit
  assign amb_x = {amb_q[10], amb_q};
  assign high_x = {high_q[10], high_q};
  assign low_x = {low_q[10], low_q};
  assign crit_x = {crit_q[10], crit_q};

  // margin lookup
  always_comb begin
    unique case (hyst)
      tsc_pkg::HYST_NONE: margin = tsc_pkg::MARGIN_NONE;
      tsc_pkg::HYST_1P5: margin = tsc_pkg::MARGIN_1P5;
      tsc_pkg::HYST_3P0: margin = tsc_pkg::MARGIN_3P0;
      tsc_pkg::HYST_6P0: margin = tsc_pkg::MARGIN_6P0;
    endcase
  end

  // raw comparisons, unaffected by event settings
  always_comb begin
    raw.crit = (amb_x >= crit_x);
    raw.high = (amb_x > high_x);
    raw.low = (amb_x < low_x);
  end

  // held high and low flags set on the raw trip, release only past the margin; crit follows raw
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= tsc_pkg::FLAGS_RESET;
    end else begin
      held.crit <= raw.crit;
      if (raw.high) begin
        held.high <= 1'b1;
      end else if (amb_x <= high_x - margin) begin
        held.high <= 1'b0;
      end
      if (raw.low) begin
        held.low <= 1'b1;
      end else if (amb_x >= low_x + margin) begin
        held.low <= 1'b0;
      end
    end
  end

endmodule : tsc_limit_cmp
`default_nettype wire

/* File: src/tsc_event_out.sv */
// event pin driver: comparator or latched interrupt, polarity, shutdown gating
// assumes cfg comes straight from the setup register and int_clr is one cycle
`timescale 1ns/100ps
`default_nettype none
module tsc_event_out (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire tsc_pkg::tsc_cfg_t cfg,
  input wire logic int_clr,
  input wire logic cond,
  // results
  output logic evt_pin,
  output logic evt_stat
);

  logic cond_prev;
  logic latch;
  logic clr_pend;
  logic clr_now;
  logic set_now;
  logic asserted;

  // a clear written in shutdown waits for normal operation
  assign clr_now = (int_clr | clr_pend) & ~cfg.halt;
  assign set_now = cfg.evt_en & cond & ~cond_prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev <= 1'b0;
    end else begin
      cond_prev <= cond;
    end
  end

  // pending clear held across shutdown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_pend <= 1'b0;
    end else if (cfg.halt) begin
      clr_pend <= clr_pend | int_clr;
    end else begin
      clr_pend <= 1'b0;
    end
  end

  // interrupt latch, a new trip beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (set_now) begin
      latch <= 1'b1;
    end else if (clr_now) begin
      latch <= 1'b0;
    end
  end

  // shutdown and disable force the deasserted level
  assign asserted = cfg.evt_en & ~cfg.halt & (cfg.evt_mode ? latch : cond);

  // pin and status registered together so they never disagree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_pin <= 1'b1;
      evt_stat <= 1'b0;
    end else begin
      evt_pin <= cfg.evt_pol ? asserted : ~asserted;
      evt_stat <= asserted;
    end
  end

endmodule : tsc_event_out
`default_nettype wire

/* File: testbench/tsc_conv_model.sv */
// converter stand-in: delivers the requested reading every fourth cycle
// assumes conv_run from the block under test, target from the bench
`timescale 1ns/100ps
`default_nettype none
module tsc_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and value wanted
  input wire logic conv_run,
  input wire logic [12:0] target,
  // result
  output logic [12:0] conv_data,
  output logic conv_valid
);
  logic [1:0] phase;
  // results stop while halted; data lines toggle between results so stale values cannot pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      conv_valid <= 1'b0;
      conv_data <= 13'h0000;
    end else begin
      phase <= phase + 2'h1;
      conv_valid <= conv_run && phase == 2'h3;
      conv_data <= (conv_run && phase == 2'h3) ? target : ~conv_data;
    end
  end
endmodule : tsc_conv_model
`default_nettype wire

/* File: testbench/tsc_setup_regs_properties.sv */
// port-level checks for the setup register block
// assumes a single clock domain; bound onto tsc_setup_regs at the foot
`timescale 1ns/100ps
`default_nettype none
module tsc_setup_regs_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit,
  // converter and pin
  input wire logic [12:0] conv_data,
  input wire logic conv_valid,
  input wire logic conv_run,
  input wire logic evt_pin
);
  logic halt_s;
  logic crit_s;
  logic win_s;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of halt and locks; locks are judged as they stood before the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_s <= 1'b0;
      crit_s <= 1'b0;
      win_s <= 1'b0;
    end else if (reg_wr && reg_addr == tsc_pkg::ADDR_SETUP) begin
      halt_s <= (crit_s || win_s) ? (halt_s && reg_wdata[8]) : reg_wdata[8];
      crit_s <= crit_s || reg_wdata[7];
      win_s <= win_s || reg_wdata[6];
    end
  end
  sequence s_setup_rd;
    reg_rd && reg_addr == tsc_pkg::ADDR_SETUP;
  endsequence
  sequence s_halted_long;
    halt_s && $past(halt_s);
  endsequence
  a_run_tracks_halt: assert property (conv_run == !halt_s) else $error("conv_run disagrees with halt");
  a_setup_zero_bits: assert property (s_setup_rd |=> reg_rdata[15:11] == 5'h00 && !reg_rdata[5])
    else $error("setup reserved or clear bit reads nonzero");
  a_lock_halt_read: assert property (s_setup_rd |=> reg_rdata[8:6] == {$past(halt_s), $past(crit_s), $past(win_s)})
    else $error("halt or lock bits read wrong");
  a_halt_stat_zero: assert property (s_setup_rd ##0 s_halted_long |=> !reg_rdata[4])
    else $error("status set while halted");
  a_cap_value: assert property (reg_rd && reg_addr == tsc_pkg::ADDR_CAP |=> reg_rdata == 16'h0001 && reg_hit)
    else $error("capability value wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > tsc_pkg::ADDR_AMB |=> reg_rdata == 16'h0000 && !reg_hit)
    else $error("unmapped read not zero");
  a_mapped_hit: assert property (reg_rd && reg_addr <= tsc_pkg::ADDR_AMB |=> reg_hit)
    else $error("mapped read without hit");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("read data moved without a read");
endmodule : tsc_setup_regs_properties
bind tsc_setup_regs tsc_setup_regs_properties u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .conv_data(conv_data), .conv_valid(conv_valid), .conv_run(conv_run), .evt_pin(evt_pin));
`default_nettype wire

/* File: testbench/temp_sensor_config_event_ctrl_test.sv */
// self-checking bench: register port, converter model, event pin
// assumes the checker binds itself; 50 ns clock
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_config_event_ctrl_test;
  typedef struct {int hyst, halt, cl, wl, en, sel, pol, mode, ip, pc, pclr, mh, ml, a, hi, lo, cr;} tsc_model_t;
  tsc_model_t s;
  logic clk, rst_n, reg_wr, reg_rd, conv_valid, conv_run, evt_pin, reg_hit;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [12:0] conv_data, target, amb_raw;
  int err_total, checks, seed, i;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  tsc_setup_regs uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_run(conv_run), .evt_pin(evt_pin));
  tsc_conv_model u_conv (.clk(clk), .rst_n(rst_n), .conv_run(conv_run), .target(target),
    .conv_data(conv_data), .conv_valid(conv_valid));
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] lim(input int v);
    return {3'h0, v[10:0], 2'h0};
  endfunction : lim
  // one evaluation of the event path per settled change, as the design sees it
  function automatic void settle();
    int m, c;
    m = (s.hyst == 0) ? 0 : (3 << s.hyst);
    if (s.a > s.hi) s.mh = 1;
    else if (s.a <= s.hi - m) s.mh = 0;
    if (s.a < s.lo) s.ml = 1;
    else if (s.a >= s.lo + m) s.ml = 0;
    c = (s.a >= s.cr) | (!s.sel & (s.mh | s.ml));
    if (!s.halt && s.pclr) begin
      s.ip = 0;
      s.pclr = 0;
    end
    if (s.en && c && !s.pc) s.ip = 1;
    s.pc = c;
  endfunction : settle
  function automatic logic stat();
    return s.en[0] & !s.halt[0] & (s.mode[0] ? s.ip[0] : s.pc[0]);
  endfunction : stat
  task rd(input logic [3:0] ad);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // write, then mirror it in the model; locks count as they stood before the write
  task wr(input logic [3:0] ad, input logic [15:0] v);
    int lk;
    lk = s.cl | s.wl;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (ad == 4'h1) begin
      if (v[5] && s.halt) s.pclr = 1;
      else if (v[5]) s.ip = 0;
      if (!lk) begin
        s.hyst = v[10:9];
        s.en = v[3];
        s.pol = v[1];
        s.mode = v[0];
      end
      if (!s.wl) s.sel = v[2];
      if (!lk || !v[8]) s.halt = v[8];
      s.cl = s.cl | v[7];
      s.wl = s.wl | v[6];
    end
    if (ad == 4'h2 && !s.wl) s.hi = $signed(v[12:2]);
    if (ad == 4'h3 && !s.wl) s.lo = $signed(v[12:2]);
    if (ad == 4'h4 && !s.cl) s.cr = $signed(v[12:2]);
    repeat (3) @(posedge clk);
    settle();
  endtask : wr
  // new reading from the converter; a halted device keeps the old one
  task amb(input int v);
    @(posedge clk);
    target <= {v[10:0], 2'($random(seed))};
    repeat (9) @(posedge clk);
    if (!s.halt) begin
      s.a = v;
      amb_raw = target;
    end
    settle();
  endtask : amb
  task check_all();
    rd(4'h1);
    chk("setup", d, {5'h00, 2'(s.hyst), s.halt[0], s.cl[0], s.wl[0], 1'b0, stat(), s.en[0], s.sel[0], s.pol[0],
      s.mode[0]});
    rd(4'h5);
    chk("ambient", d, {s.a >= s.cr, s.a > s.hi, s.a < s.lo, amb_raw});
    chk("evt_pin", 16'(evt_pin), 16'(stat() ? s.pol[0] : !s.pol[0]));
  endtask : check_all
  task do_reset();
    rst_n <= 1'b0;
    target <= 13'h0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s = '{default: 0};
    amb_raw = 13'h0000;
    settle();
  endtask : do_reset
  task results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // about 1600 cycles expected; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    seed = 20070;
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    target = 13'h0000;
    do_reset();
    check_all();
    rd(4'h0);
    chk("capability", d, 16'h0001);
    rd(4'h9);
    chk("unmapped", {d[15:1], reg_hit}, 16'h0000);
    wr(4'h2, 16'hffff);
    rd(4'h2);
    chk("high_limit", d, 16'h1ffc);
    $display("test reset_values done");
    // comparator mode with random margin, select, polarity, limits and readings
    for (i = 0; i < 40; i++) begin
      wr(4'h1, 16'h0008 | (16'($random(seed)) & 16'h0606));
      wr(4'h2, lim($random(seed) % 40));
      wr(4'h3, lim($random(seed) % 40));
      wr(4'h4, lim($random(seed) % 40));
      amb($random(seed) % 40);
      check_all();
    end
    $display("test comparator_random done");
    wr(4'h2, lim(40));
    wr(4'h3, lim(-40));
    wr(4'h4, lim(100));
    amb(0);
    wr(4'h1, 16'h002b);
    amb(60);
    check_all();
    amb(0);
    check_all();
    wr(4'h1, 16'h002b);
    check_all();
    amb(60);
    amb(0);
    wr(4'h1, 16'h010b);
    check_all();
    amb(60);
    check_all();
    wr(4'h1, 16'h012b);
    amb(0);
    wr(4'h1, 16'h000b);
    amb(0);
    check_all();
    $display("test interrupt_halt done");
    wr(4'h1, 16'h0000);
    wr(4'h1, 16'h0180);
    check_all();
    wr(4'h1, 16'h060f);
    check_all();
    wr(4'h1, 16'h0100);
    wr(4'h4, lim(5));
    wr(4'h2, lim(7));
    rd(4'h4);
    chk("crit_limit", d, lim(s.cr));
    wr(4'h1, 16'h0040);
    wr(4'h1, 16'h0000);
    wr(4'h3, lim(9));
    rd(4'h3);
    chk("low_limit", d, lim(s.lo));
    check_all();
    do_reset();
    check_all();
    $display("test locks done");
    results();
  end
endmodule : temp_sensor_config_event_ctrl_test
`default_nettype wire
